// ===== hdl/mfc_pkg.sv
`timescale 1ns/1ps
package mfc_pkg;
	localparam int MFC_ADDR_W = 12;
	localparam int MFC_FIELD_W = 2;
	localparam int MFC_IR_W = 12;
	// positions after the three-place shift of the instruction register
	localparam int MFC_FC_BIT = 6;
	localparam int MFC_FLD_LO_BIT = 7;
	localparam int MFC_FLD_HI_BIT = 8;
	localparam logic [MFC_FIELD_W-1:0] MFC_FIELD_ZERO = 2'h0;
	localparam logic [MFC_ADDR_W-1:0] MFC_ADDR_ZERO = 12'h000;
	localparam logic [MFC_ADDR_W-1:0] MFC_ADDR_ONES = 12'hFFF;

	// one-cycle strobes from the control sequencer, same clock
	typedef struct packed {
		logic bp1;
		logic bp3;
		logic bp5;
		logic bp6;
		logic bp7;
		logic ep0;
		logic ep1;
		logic pu0;
		logic pu1;
	} mfc_phase_t;

	typedef struct packed {
		logic [MFC_IR_W-1:0] ir_shifted;
		logic two_word_flag;
		logic jump_op;
		logic subroutine_call_op;
		logic indirect_flag;
		logic reserved_location_qual;
	} mfc_instr_t;

	typedef enum logic [1:0] {
		MFC_IRQ_IDLE = 2'h0,
		MFC_IRQ_FORCED = 2'h1,
		MFC_IRQ_SAVED = 2'h3
	} mfc_irq_state_t;
endpackage : mfc_pkg

module mfc_addr_match
	import mfc_pkg::*;
#(
	parameter int ADDR_W = MFC_ADDR_W
)
(
	input wire logic [ADDR_W-1:0] save_addr_i,
	input wire logic [ADDR_W-1:0] proc_addr_i,
	input wire logic indirect_flag_i,
	input wire logic reserved_location_qual_i,
	output logic save_address_equal_o
);
	logic edge_addr;

	// all-zero and all-one locations never qualify as a return pointer
	assign edge_addr = (proc_addr_i == MFC_ADDR_ZERO[ADDR_W-1:0])
		|| (proc_addr_i == MFC_ADDR_ONES[ADDR_W-1:0]);
	assign save_address_equal_o = (save_addr_i == proc_addr_i) && indirect_flag_i
		&& !reserved_location_qual_i && !edge_addr;
endmodule : mfc_addr_match

// ===== hdl/mfc_field_ctrl.sv
`timescale 1ns/1ps
module mfc_field_ctrl
	import mfc_pkg::*;
#(
	parameter int ADDR_W = MFC_ADDR_W
)
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire mfc_phase_t phase_i,
	input wire mfc_instr_t instr_i,
	input wire logic [ADDR_W-1:0] proc_addr_i,
	input wire logic irq_pending_flag_i,
	input wire logic power_not_ready_i,
	input wire logic steal_active_i,
	input wire logic [MFC_FIELD_W-1:0] steal_field_i,
	output logic field_select_lo_o,
	output logic field_select_hi_o,
	output logic operand_field_override_o,
	output logic far_jump_call_strobe_o,
	output logic call_return_match_o,
	output logic irq_return_match_o,
	output logic any_return_match_o,
	output logic irq_field_zero_force_o,
	output logic [MFC_FIELD_W-1:0] current_field_o,
	output logic [MFC_FIELD_W-1:0] call_save_field_o,
	output logic [MFC_FIELD_W-1:0] irq_save_field_o
);
	logic [MFC_FIELD_W-1:0] field_r, field_nxt;
	logic [MFC_FIELD_W-1:0] call_fld_r, call_fld_nxt;
	logic [MFC_FIELD_W-1:0] irq_fld_r, irq_fld_nxt;
	logic [ADDR_W-1:0] call_addr_r, call_addr_nxt;
	logic [ADDR_W-1:0] irq_addr_r, irq_addr_nxt;
	logic far_jump_call_strobe_r, far_jump_call_strobe_nxt;
	logic call_en_r, call_en_nxt;
	logic tw_ovr_r, tw_ovr_nxt;
	logic ret_ovr_r, ret_ovr_nxt;
	logic call_match_r, call_match_nxt;
	logic irq_match_r, irq_match_nxt;
	mfc_irq_state_t irq_st_r, irq_st_nxt;
	logic [MFC_FIELD_W-1:0] sel_r, sel_nxt;
	logic any_match_r, any_match_nxt;
	logic call_eq;
	logic irq_eq;
	logic fc_bit;
	logic [MFC_FIELD_W-1:0] ir_field;

	assign fc_bit = instr_i.ir_shifted[MFC_FC_BIT];
	assign ir_field = {instr_i.ir_shifted[MFC_FLD_HI_BIT], instr_i.ir_shifted[MFC_FLD_LO_BIT]};

	mfc_addr_match #(
		.ADDR_W(ADDR_W)
	) u_call_cmp (
		.save_addr_i(call_addr_r),
		.proc_addr_i(proc_addr_i),
		.indirect_flag_i(instr_i.indirect_flag),
		.reserved_location_qual_i(instr_i.reserved_location_qual),
		.save_address_equal_o(call_eq)
	);

	mfc_addr_match #(
		.ADDR_W(ADDR_W)
	) u_irq_cmp (
		.save_addr_i(irq_addr_r),
		.proc_addr_i(proc_addr_i),
		.indirect_flag_i(instr_i.indirect_flag),
		.reserved_location_qual_i(instr_i.reserved_location_qual),
		.save_address_equal_o(irq_eq)
	);

	always_comb
	begin
		field_nxt = field_r;
		call_fld_nxt = call_fld_r;
		irq_fld_nxt = irq_fld_r;
		call_addr_nxt = call_addr_r;
		irq_addr_nxt = irq_addr_r;
		far_jump_call_strobe_nxt = far_jump_call_strobe_r;
		call_en_nxt = call_en_r;
		tw_ovr_nxt = tw_ovr_r;
		ret_ovr_nxt = ret_ovr_r;
		call_match_nxt = call_match_r;
		irq_match_nxt = irq_match_r;
		irq_st_nxt = irq_st_r;
		// clears first so a same-cycle set below wins
		if (phase_i.bp1)
		begin
			far_jump_call_strobe_nxt = 1'b0;
			call_en_nxt = 1'b0;
			tw_ovr_nxt = 1'b0;
			ret_ovr_nxt = 1'b0;
			call_match_nxt = 1'b0;
			irq_match_nxt = 1'b0;
		end
		// first BP3 sees two_word_flag low, so only the second phase decodes
		if (phase_i.bp3 && instr_i.two_word_flag && fc_bit
			&& (instr_i.jump_op || instr_i.subroutine_call_op))
		begin
			far_jump_call_strobe_nxt = 1'b1;
			call_en_nxt = instr_i.subroutine_call_op;
		end
		if (phase_i.ep0)
		begin
			if (far_jump_call_strobe_r)
			begin
				field_nxt = ir_field;
				// old field is dropped unless this is a call
				if (call_en_r)
				begin
					call_fld_nxt = field_r;
				end
			end
			else if (instr_i.two_word_flag && fc_bit)
			begin
				tw_ovr_nxt = 1'b1;
			end
			if (call_match_r && !instr_i.jump_op)
			begin
				ret_ovr_nxt = 1'b1;
			end
		end
		if (phase_i.ep1 && call_en_r)
		begin
			call_addr_nxt = proc_addr_i;
		end
		if (phase_i.bp5 && call_eq)
		begin
			call_match_nxt = 1'b1;
		end
		if (phase_i.bp6 && irq_eq)
		begin
			irq_match_nxt = 1'b1;
		end
		// power failing: keep the pointer so the return can be retried
		if (phase_i.bp7 && instr_i.jump_op && !power_not_ready_i)
		begin
			if (call_match_r)
			begin
				call_addr_nxt = MFC_ADDR_ZERO[ADDR_W-1:0];
			end
			if (irq_match_r)
			begin
				irq_addr_nxt = MFC_ADDR_ZERO[ADDR_W-1:0];
			end
		end
		if (phase_i.pu0 && instr_i.jump_op && (call_match_r || irq_match_r))
		begin
			field_nxt = call_match_r ? call_fld_r : irq_fld_r;
		end
		case (irq_st_r)
			MFC_IRQ_IDLE:
			begin
				if (phase_i.pu0 && irq_pending_flag_i)
				begin
					irq_st_nxt = MFC_IRQ_FORCED;
				end
			end
			MFC_IRQ_FORCED:
			begin
				if (phase_i.pu1)
				begin
					irq_addr_nxt = proc_addr_i;
					irq_fld_nxt = field_r;
					field_nxt = MFC_FIELD_ZERO;
					irq_st_nxt = MFC_IRQ_SAVED;
				end
			end
			MFC_IRQ_SAVED:
			begin
				if (phase_i.pu1)
				begin
					irq_st_nxt = MFC_IRQ_IDLE;
				end
			end
			default:
			begin
				irq_st_nxt = MFC_IRQ_IDLE;
			end
		endcase
	end

	// output mux from next values so the select flop lines up with its causes
	always_comb
	begin
		any_match_nxt = call_match_nxt | irq_match_nxt;
		if (steal_active_i)
		begin
			sel_nxt = steal_field_i;
		end
		else if (ret_ovr_nxt)
		begin
			sel_nxt = call_fld_nxt;
		end
		else if (tw_ovr_nxt)
		begin
			sel_nxt = ir_field;
		end
		else if (irq_st_nxt != MFC_IRQ_IDLE)
		begin
			sel_nxt = MFC_FIELD_ZERO;
		end
		else
		begin
			sel_nxt = field_nxt;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			field_r <= MFC_FIELD_ZERO;
			call_fld_r <= MFC_FIELD_ZERO;
			irq_fld_r <= MFC_FIELD_ZERO;
			call_addr_r <= MFC_ADDR_ZERO[ADDR_W-1:0];
			irq_addr_r <= MFC_ADDR_ZERO[ADDR_W-1:0];
			far_jump_call_strobe_r <= 1'b0;
			call_en_r <= 1'b0;
			tw_ovr_r <= 1'b0;
			ret_ovr_r <= 1'b0;
			call_match_r <= 1'b0;
			irq_match_r <= 1'b0;
			irq_st_r <= MFC_IRQ_IDLE;
			sel_r <= MFC_FIELD_ZERO;
			any_match_r <= 1'b0;
		end
		else
		begin
			field_r <= field_nxt;
			call_fld_r <= call_fld_nxt;
			irq_fld_r <= irq_fld_nxt;
			call_addr_r <= call_addr_nxt;
			irq_addr_r <= irq_addr_nxt;
			far_jump_call_strobe_r <= far_jump_call_strobe_nxt;
			call_en_r <= call_en_nxt;
			tw_ovr_r <= tw_ovr_nxt;
			ret_ovr_r <= ret_ovr_nxt;
			call_match_r <= call_match_nxt;
			irq_match_r <= irq_match_nxt;
			irq_st_r <= irq_st_nxt;
			sel_r <= sel_nxt;
			any_match_r <= any_match_nxt;
		end
	end

	assign field_select_lo_o = sel_r[0];
	assign field_select_hi_o = sel_r[1];
	assign operand_field_override_o = tw_ovr_r;
	assign far_jump_call_strobe_o = far_jump_call_strobe_r;
	assign call_return_match_o = call_match_r;
	assign irq_return_match_o = irq_match_r;
	assign any_return_match_o = any_match_r;
	assign irq_field_zero_force_o = irq_st_r[0]; // codes 0, 1, 3: low bit set in both forcing states
	assign current_field_o = field_r;
	assign call_save_field_o = call_fld_r;
	assign irq_save_field_o = irq_fld_r;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	sequence s_irq_entry;
		(irq_st_r == MFC_IRQ_IDLE) && phase_i.pu0 && irq_pending_flag_i && !phase_i.pu1
		&& !steal_active_i;
	endsequence
	sequence s_irq_save;
		(irq_st_r == MFC_IRQ_FORCED) && phase_i.pu1 && !phase_i.pu0;
	endsequence
	tw_override_sel_a: assert property (
		phase_i.ep0 && !phase_i.bp1 && !far_jump_call_strobe_r && instr_i.two_word_flag && fc_bit
		&& !call_match_r && !steal_active_i
		|=> tw_ovr_r && ({field_select_hi_o, field_select_lo_o} == $past(ir_field)))
		else $error("two-word override did not select instruction field");
	step_one_clear_a: assert property (
		phase_i.bp1 && !phase_i.ep0 && !phase_i.bp5 && !phase_i.bp6
		|=> !tw_ovr_r && !ret_ovr_r && !call_match_r && !irq_match_r)
		else $error("step one left an override or match flag set");
	far_jump_load_a: assert property (
		phase_i.ep0 && far_jump_call_strobe_r && !phase_i.pu1 && !phase_i.pu0
		|=> field_r == $past(ir_field))
		else $error("far jump did not load the field register");
	call_field_save_a: assert property (
		phase_i.ep0 && far_jump_call_strobe_r && call_en_r |=> call_fld_r == $past(field_r))
		else $error("call did not save the old field");
	call_addr_save_a: assert property (
		phase_i.ep1 && call_en_r && !phase_i.bp7 |=> call_addr_r == $past(proc_addr_i))
		else $error("call-save address not loaded at EP1");
	edge_addr_match_a: assert property (
		phase_i.bp5 && !call_match_r
		&& (proc_addr_i == MFC_ADDR_ZERO[ADDR_W-1:0] || proc_addr_i == MFC_ADDR_ONES[ADDR_W-1:0])
		|=> !call_match_r)
		else $error("return match raised on a reserved address");
	far_strobe_a: assert property (
		phase_i.bp3 && instr_i.two_word_flag && fc_bit && instr_i.jump_op
		##1 !phase_i.bp1 [*2] |-> far_jump_call_strobe_o)
		else $error("far jump strobe missing after BP3 decode");
	return_clear_a: assert property (
		phase_i.bp7 && instr_i.jump_op && call_match_r && !power_not_ready_i && !phase_i.ep1
		|=> call_addr_r == MFC_ADDR_ZERO[ADDR_W-1:0])
		else $error("call-save address not cleared on return jump");
	return_restore_a: assert property (
		phase_i.pu0 && instr_i.jump_op && call_match_r && !phase_i.ep0
		&& irq_st_r != MFC_IRQ_FORCED
		|=> field_r == $past(call_fld_r))
		else $error("return jump did not restore the caller field");
	irq_force_a: assert property (
		s_irq_entry ##1 !ret_ovr_r && !tw_ovr_r
		|-> irq_field_zero_force_o && !field_select_hi_o && !field_select_lo_o)
		else $error("interrupt entry did not force field zero");
	irq_save_a: assert property (
		s_irq_save |=> field_r == MFC_FIELD_ZERO && irq_fld_r == $past(field_r)
		&& irq_addr_r == $past(proc_addr_i) && irq_field_zero_force_o)
		else $error("interrupt save transfers wrong at PU1");
	irq_release_a: assert property (
		(irq_st_r == MFC_IRQ_SAVED) && phase_i.pu1 |=> !irq_field_zero_force_o)
		else $error("field zero force not released at next PU1");
endmodule : mfc_field_ctrl

// ===== testbench/mfc_seq_model.sv
`timescale 1ns/1ps
module mfc_seq_model
	import mfc_pkg::*;
(
	input wire logic clk_sys_i,
	output mfc_phase_t phase_o
);
	initial
	begin
		phase_o = '0;
	end

	// idx: 8 bp1, 7 bp3, 6 bp5, 5 bp6, 4 bp7, 3 ep0, 2 ep1, 1 pu0, 0 pu1
	// one strobe per step, never two at once, like the real sequencer
	task pulse(input int idx);
		@(posedge clk_sys_i);
		phase_o <= mfc_phase_t'(9'h001 << idx);
		@(posedge clk_sys_i);
		phase_o <= '0;
		#1;
	endtask : pulse
endmodule : mfc_seq_model

// ===== testbench/memory_field_control_tb_top.sv
`timescale 1ns/1ps
module memory_field_control_tb_top
	import mfc_pkg::*;
;
	logic clk_sys_i;
	logic reset_i;
	mfc_phase_t phase;
	mfc_instr_t ins;
	logic [MFC_ADDR_W-1:0] addr;
	logic irq, pnr, steal;
	logic tw, rq;
	logic [11:0] jk;
	logic [1:0] sf, cf, csf, isf;
	logic lo, hi, ovr, fjs, crm, irm, arm, frc;
	int errors;
	int checks;

	initial
	begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	mfc_seq_model seq (.clk_sys_i(clk_sys_i), .phase_o(phase));

	mfc_field_ctrl uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .phase_i(phase),
		.instr_i(ins), .proc_addr_i(addr), .irq_pending_flag_i(irq),
		.power_not_ready_i(pnr), .steal_active_i(steal), .steal_field_i(sf),
		.field_select_lo_o(lo), .field_select_hi_o(hi), .operand_field_override_o(ovr),
		.far_jump_call_strobe_o(fjs), .call_return_match_o(crm),
		.irq_return_match_o(irm), .any_return_match_o(arm),
		.irq_field_zero_force_o(frc), .current_field_o(cf),
		.call_save_field_o(csf), .irq_save_field_o(isf));

	task chk(input logic [11:0] seen, input logic [11:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task test_done;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	// jk fills the bits the block must ignore; tw low gives a single-word shape
	task setins(input logic [1:0] f, input logic fc, j, c, i, input logic [11:0] a);
		@(posedge clk_sys_i);
		ins <= '{{jk[11:9], f, fc, jk[5:0]}, tw, j, c, i, rq};
		addr <= a;
	endtask : setins

	initial
	begin
		#20000;
		errors++;
		test_done();
	end

	initial
	begin
		errors = 0;
		checks = 0;
		reset_i = 1'b1;
		ins = '0;
		addr = '0;
		irq = 1'b0;
		pnr = 1'b0;
		steal = 1'b0;
		sf = 2'h3;
		tw = 1'b1;
		rq = 1'b0;
		jk = 12'h000;
		repeat (5) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		#1;
		chk(cf, 2'h0);
		chk({hi, lo}, 2'h0);
		jk = 12'hE3F;
		setins(2'h2, 1'b1, 1'b1, 1'b0, 1'b0, 12'h000);
		seq.pulse(7);
		chk(fjs, 1'b1);
		seq.pulse(3);
		chk(cf, 2'h2);
		chk(csf, 2'h0);
		chk({hi, lo}, 2'h2);
		seq.pulse(8);
		chk(fjs, 1'b0);
		setins(2'h1, 1'b1, 1'b0, 1'b1, 1'b0, 12'h123);
		seq.pulse(7);
		chk(cf, 2'h2);
		chk(csf, 2'h0);
		seq.pulse(3);
		chk(cf, 2'h1);
		chk(csf, 2'h2);
		seq.pulse(2);
		seq.pulse(8);
		setins(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 12'h123);
		seq.pulse(6);
		chk(crm, 1'b0);
		rq = 1'b1;
		setins(2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 12'h123);
		seq.pulse(6);
		chk(crm, 1'b0);
		rq = 1'b0;
		setins(2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 12'h123);
		seq.pulse(6);
		chk(crm, 1'b1);
		chk(arm, 1'b1);
		seq.pulse(3);
		chk({hi, lo}, 2'h2);
		chk(cf, 2'h1);
		seq.pulse(8);
		chk(crm, 1'b0);
		chk({hi, lo}, 2'h1);
		tw = 1'b0;
		setins(2'h3, 1'b1, 1'b1, 1'b0, 1'b0, 12'h050);
		seq.pulse(7);
		chk(fjs, 1'b0);
		seq.pulse(3);
		chk(ovr, 1'b0);
		chk({hi, lo}, 2'h1);
		tw = 1'b1;
		setins(2'h3, 1'b1, 1'b0, 1'b0, 1'b0, 12'h050);
		seq.pulse(3);
		chk(ovr, 1'b1);
		chk({hi, lo}, 2'h3);
		chk(cf, 2'h1);
		seq.pulse(8);
		chk(ovr, 1'b0);
		chk({hi, lo}, 2'h1);
		@(posedge clk_sys_i);
		steal <= 1'b1;
		@(posedge clk_sys_i);
		sf <= 2'h2;
		#1;
		chk({hi, lo}, 2'h3);
		@(posedge clk_sys_i);
		steal <= 1'b0;
		#1;
		chk({hi, lo}, 2'h2);
		@(posedge clk_sys_i);
		#1;
		chk({hi, lo}, 2'h1);
		setins(2'h0, 1'b0, 1'b1, 1'b0, 1'b1, 12'h123);
		pnr <= 1'b1;
		seq.pulse(6);
		chk(crm, 1'b1);
		seq.pulse(4);
		seq.pulse(8);
		seq.pulse(6);
		chk(crm, 1'b1);
		@(posedge clk_sys_i);
		pnr <= 1'b0;
		seq.pulse(4);
		seq.pulse(1);
		chk(cf, 2'h2);
		seq.pulse(8);
		seq.pulse(6);
		chk(crm, 1'b0);
		seq.pulse(8);
		setins(2'h0, 1'b0, 1'b1, 1'b0, 1'b1, 12'h000);
		seq.pulse(6);
		chk(crm, 1'b0);
		seq.pulse(5);
		chk(irm, 1'b0);
		seq.pulse(8);
		setins(2'h2, 1'b1, 1'b0, 1'b1, 1'b0, 12'hFFF);
		seq.pulse(7);
		seq.pulse(3);
		seq.pulse(2);
		seq.pulse(8);
		setins(2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 12'hFFF);
		seq.pulse(6);
		chk(crm, 1'b0);
		seq.pulse(8);
		jk = 12'h000;
		@(posedge clk_sys_i);
		irq <= 1'b1;
		seq.pulse(1);
		chk(frc, 1'b1);
		chk({hi, lo}, 2'h0);
		@(posedge clk_sys_i);
		irq <= 1'b0;
		setins(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 12'h321);
		seq.pulse(0);
		chk(isf, 2'h2);
		chk(cf, 2'h0);
		chk(frc, 1'b1);
		seq.pulse(0);
		chk(frc, 1'b0);
		chk({hi, lo}, 2'h0);
		setins(2'h0, 1'b0, 1'b1, 1'b0, 1'b1, 12'h321);
		seq.pulse(5);
		chk(irm, 1'b1);
		chk(arm, 1'b1);
		seq.pulse(4);
		seq.pulse(1);
		chk(cf, 2'h2);
		seq.pulse(8);
		chk(irm, 1'b0);
		test_done();
	end
endmodule : memory_field_control_tb_top
